// ===== rtc_regs.svh
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ---------------------------------------------------------------
// Register port geometry
// ---------------------------------------------------------------
`define RTC_ADDR_W        8
`define RTC_DATA_W        32

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define RTC_OFF_CTRL      8'h00
`define RTC_OFF_STATUS    8'h04
`define RTC_OFF_MASK      8'h08
`define RTC_OFF_RELOAD    8'h0C
`define RTC_OFF_PRESC     8'h10
`define RTC_OFF_COUNT     8'h14
`define RTC_OFF_ALARM     8'h18
`define RTC_OFF_BKP_BASE  8'h20
`define RTC_BKP_NUM       10
`define RTC_BKP_LAST      8'h44

// ---------------------------------------------------------------
// Widths, reset values and divider counts
// ---------------------------------------------------------------
`define RTC_PRESC_W       20
`define RTC_BKP_W         16
`define RTC_RELOAD_RST    20'h07FFF
`define RTC_COUNT_RST     32'h0000_0000
`define RTC_ALARM_RST     32'hFFFF_FFFF
`define RTC_HSE_DIV_LAST  7'h7F
`define RTC_CAL_HALF_LAST 5'h1F

`endif

// ===== rtc_pkg.sv
`include "rtc_regs.svh"

package rtc_pkg;

   // ------------------------------------------------------------
   // Clock source selection
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_OFF = 2'b00,
      SRC_LSE = 2'b01,
      SRC_LSI = 2'b10,
      SRC_HSE = 2'b11
   } rtc_src_t;

   // ------------------------------------------------------------
   // Register layouts
   // ------------------------------------------------------------
   typedef struct packed {
      logic     cal_en;
      rtc_src_t src;
      logic     run;
   } rtc_ctrl_t;

   typedef struct packed {
      logic periodic;
      logic alarm;
   } rtc_irq_t;

   typedef struct packed {
      logic [`RTC_ADDR_W-1:0] addr;
      logic [`RTC_DATA_W-1:0] wdata;
      logic                   wr;
      logic                   rd;
   } bus_req_t;

endpackage

// ===== rtc_prescaler.sv
`include "rtc_regs.svh"

module rtc_prescaler (
   // Clock and reset
   input  wire logic                    clk,
   input  wire logic                    srst,
   // Control
   input  wire logic                    tick_en,
   input  wire logic                    restart,
   input  wire logic [`RTC_PRESC_W-1:0] reload,
   // Status
   output logic      [`RTC_PRESC_W-1:0] count,
   output logic                         rollover
);
   import rtc_pkg::*;

   // ------------------------------------------------------------
   // Down counter, divides by reload plus one
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         count    <= `RTC_RELOAD_RST;
         rollover <= 1'b0;
      end else begin
         rollover <= 1'b0;
         if (restart) begin
            count <= reload;
         end else if (tick_en) begin
            if (count == '0) begin
               count    <= reload;
               rollover <= 1'b1;
            end else begin
               count <= count - `RTC_PRESC_W'(1);
            end
         end
      end
   end

   a_presc_wrap: assert property (
      @(posedge clk) disable iff (srst)
      (tick_en && !restart && count == '0)
         |=> (rollover && count == $past(reload)))
      else $error("prescaler did not wrap to reload");

endmodule

// ===== rtc_counter_alarm_backup.sv
// Chosen here: the plain strobed port and the register offsets.
`include "rtc_regs.svh"
// How it works
// - Free 32-bit counter, software loadable; alarm flag when it equals compare.
// - 20-bit prescaler divides by reload+1; reset reload gives 1 s at 32.768 kHz.
// - Tick source: low-speed crystal, low-power RC, or high-speed clock/128.
// - Separate alarm and periodic interrupt outputs, plus a combined one.
// - 512 Hz calibration output from the selected clock, enabled by control.
// - Ten 16-bit backup words, read/write, kept over the main reset.
module rtc_counter_alarm_backup (
   // Clock and resets
   input  wire logic                   clk,
   input  wire logic                   srst,
   input  wire logic                   bkp_domain_rst,
   // Clock source pins
   input  wire logic                   lse_clk_pin,
   input  wire logic                   lsi_clk_pin,
   input  wire logic                   hse_clk_pin,
   // Register port
   input  wire rtc_pkg::bus_req_t      bus,
   output logic      [`RTC_DATA_W-1:0] rdata,
   // Interrupts and calibration
   output logic                        alarm_irq,
   output logic                        periodic_irq,
   output logic                        irq,
   output logic                        cal_out
);
   import rtc_pkg::*;

   // ------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------
   function automatic logic bkp_hit(input logic [`RTC_ADDR_W-1:0] a);
      bkp_hit = (a >= `RTC_OFF_BKP_BASE) && (a <= `RTC_BKP_LAST) &&
                (a[1:0] == 2'b00);
   endfunction

   function automatic logic [3:0] bkp_idx(input logic [`RTC_ADDR_W-1:0] a);
      logic [`RTC_ADDR_W-1:0] d;
      d = a - `RTC_OFF_BKP_BASE;
      bkp_idx = d[5:2];
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   rtc_ctrl_t                ctrl;
   rtc_irq_t                 status;
   rtc_irq_t                 next_status;
   rtc_irq_t                 mask;
   logic [`RTC_PRESC_W-1:0]  reload;
   logic [`RTC_PRESC_W-1:0]  presc_count;
   logic                     rollover;
   logic [31:0]              count;
   logic [31:0]              alarm;
   logic                     eq_prev;
   logic                     alarm_set;
   logic [2:0]               pin_edge;
   logic [6:0]               hse_div;
   logic                     src_tick;
   logic [4:0]               cal_div;
   logic [`RTC_BKP_W-1:0]    backup [`RTC_BKP_NUM];
   logic                     wr_ctrl;
   logic                     wr_status;
   logic                     wr_mask;
   logic                     wr_reload;
   logic                     wr_count;
   logic                     wr_alarm;
   logic                     wr_bkp;

   assign wr_ctrl   = bus.wr && bus.addr == `RTC_OFF_CTRL;
   assign wr_status = bus.wr && bus.addr == `RTC_OFF_STATUS;
   assign wr_mask   = bus.wr && bus.addr == `RTC_OFF_MASK;
   assign wr_reload = bus.wr && bus.addr == `RTC_OFF_RELOAD;
   assign wr_count  = bus.wr && bus.addr == `RTC_OFF_COUNT;
   assign wr_alarm  = bus.wr && bus.addr == `RTC_OFF_ALARM;
   assign wr_bkp    = bus.wr && bkp_hit(bus.addr);

   // ------------------------------------------------------------
   // Pin synchronisers and rising-edge detect
   // ------------------------------------------------------------
   logic [2:0] pin_raw;
   assign pin_raw = {hse_clk_pin, lsi_clk_pin, lse_clk_pin};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         logic s1;
         logic s2;
         logic s3;
         always_ff @(posedge clk) begin
            if (srst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else begin
               s1 <= pin_raw[gi];
               s2 <= s1;
               s3 <= s2;
            end
         end
         assign pin_edge[gi] = s2 & ~s3;
      end
   endgenerate

   // ------------------------------------------------------------
   // Tick source selection
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         hse_div <= '0;
      end else if (pin_edge[2]) begin
         hse_div <= hse_div + 7'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         src_tick <= 1'b0;
      end else begin
         case (ctrl.src)
            SRC_LSE: src_tick <= pin_edge[0];
            SRC_LSI: src_tick <= pin_edge[1];
            SRC_HSE: src_tick <= pin_edge[2] &&
                                 hse_div == `RTC_HSE_DIV_LAST;
            default: src_tick <= 1'b0;
         endcase
      end
   end

   a_hse_div128: assert property (
      @(posedge clk) disable iff (srst)
      (ctrl.src == SRC_HSE && pin_edge[2] && hse_div != `RTC_HSE_DIV_LAST)
         |=> !src_tick)
      else $error("high-speed tick not divided by 128");

   // ------------------------------------------------------------
   // Prescaler
   // ------------------------------------------------------------
   rtc_prescaler u_presc (
      .clk      (clk),
      .srst     (srst),
      .tick_en  (src_tick && ctrl.run),
      .restart  (wr_reload),
      .reload   (wr_reload ? bus.wdata[`RTC_PRESC_W-1:0] : reload),
      .count    (presc_count),
      .rollover (rollover)
   );

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl   <= '0;
         mask   <= '0;
         reload <= `RTC_RELOAD_RST;
         alarm  <= `RTC_ALARM_RST;
      end else begin
         if (wr_ctrl) ctrl <= rtc_ctrl_t'(bus.wdata[3:0]);
         if (wr_mask) mask <= rtc_irq_t'(bus.wdata[1:0]);
         if (wr_reload) reload <= bus.wdata[`RTC_PRESC_W-1:0];
         if (wr_alarm) alarm <= bus.wdata;
      end
   end

   // ------------------------------------------------------------
   // Counter and alarm compare
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         count <= `RTC_COUNT_RST;
      end else if (wr_count) begin
         count <= bus.wdata;
      end else if (rollover) begin
         count <= count + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         eq_prev <= 1'b0;
      end else begin
         eq_prev <= (count == alarm);
      end
   end

   // Flag on arrival at the compare value, not while it stays equal
   assign alarm_set = (count == alarm) && !eq_prev;

   a_count_step: assert property (
      @(posedge clk) disable iff (srst)
      (rollover && !wr_count) |=> (count == $past(count) + 32'h1))
      else $error("counter missed a prescaler rollover");

   // ------------------------------------------------------------
   // Interrupt status, mask and outputs
   // ------------------------------------------------------------
   always_comb begin
      next_status = status;
      if (wr_status) next_status = status & ~rtc_irq_t'(bus.wdata[1:0]);
      // Set wins over a same-cycle clear
      if (alarm_set) next_status.alarm = 1'b1;
      if (rollover) next_status.periodic = 1'b1;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         status       <= '0;
         alarm_irq    <= 1'b0;
         periodic_irq <= 1'b0;
         irq          <= 1'b0;
      end else begin
         status       <= next_status;
         alarm_irq    <= status.alarm & mask.alarm;
         periodic_irq <= status.periodic & mask.periodic;
         irq          <= |(status & mask);
      end
   end

   a_alarm_flag: assert property (
      @(posedge clk) disable iff (srst)
      alarm_set |=> status.alarm)
      else $error("alarm match did not set the flag");

   a_periodic_flag: assert property (
      @(posedge clk) disable iff (srst)
      rollover |=> status.periodic ##1
         (periodic_irq == $past(mask.periodic)))
      else $error("rollover did not raise periodic flag");

   a_alarm_irq: assert property (
      @(posedge clk) disable iff (srst)
      (status.alarm && mask.alarm) |=> (alarm_irq && irq))
      else $error("unmasked alarm not on interrupt outputs");

   // ------------------------------------------------------------
   // Calibration output, 32 ticks per half period
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || !ctrl.cal_en) begin
         cal_div <= '0;
         cal_out <= 1'b0;
      end else if (src_tick) begin
         cal_div <= cal_div + 5'h01;
         if (cal_div == `RTC_CAL_HALF_LAST) cal_out <= ~cal_out;
      end
   end

   a_cal_toggle: assert property (
      @(posedge clk) disable iff (srst)
      (ctrl.cal_en && !wr_ctrl && src_tick &&
       cal_div == `RTC_CAL_HALF_LAST) |=> (cal_out != $past(cal_out)))
      else $error("calibration output failed to toggle");

   // ------------------------------------------------------------
   // Backup words, untouched by the main reset
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (bkp_domain_rst) begin
         for (int k = 0; k < `RTC_BKP_NUM; k++) begin
            backup[k] <= '0;
         end
      end else if (wr_bkp) begin
         backup[bkp_idx(bus.addr)] <= bus.wdata[`RTC_BKP_W-1:0];
      end
   end

   a_bkp_write: assert property (
      @(posedge clk) disable iff (srst)
      (wr_bkp && !bkp_domain_rst && bus.addr == `RTC_OFF_BKP_BASE)
         |=> (backup[0] == $past(bus.wdata[`RTC_BKP_W-1:0])))
      else $error("backup word not written");

   // ------------------------------------------------------------
   // Read data, valid only in the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst || !bus.rd) begin
         rdata <= '0;
      end else if (bkp_hit(bus.addr)) begin
         rdata <= {16'h0000, backup[bkp_idx(bus.addr)]};
      end else begin
         case (bus.addr)
            `RTC_OFF_CTRL:   rdata <= {28'h0, ctrl};
            `RTC_OFF_STATUS: rdata <= {30'h0, status};
            `RTC_OFF_MASK:   rdata <= {30'h0, mask};
            `RTC_OFF_RELOAD: rdata <= {12'h0, reload};
            `RTC_OFF_PRESC:  rdata <= {12'h0, presc_count};
            `RTC_OFF_COUNT:  rdata <= count;
            `RTC_OFF_ALARM:  rdata <= alarm;
            default:         rdata <= '0;
         endcase
      end
   end

endmodule

// ===== testbench.sv
`include "rtc_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import rtc_pkg::*;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                   clk;
   logic                   srst;
   logic                   bkp_domain_rst;
   logic [2:0]             pins;
   bus_req_t               bus;
   logic [`RTC_DATA_W-1:0] rdata;
   logic                   alarm_irq;
   logic                   periodic_irq;
   logic                   irq;
   logic                   cal_out;
   logic [31:0]            got;
   int                     errors;
   int                     checks_done;
   int                     cycles;

   rtc_counter_alarm_backup u_rtc_counter_alarm_backup (
      .clk            (clk),
      .srst           (srst),
      .bkp_domain_rst (bkp_domain_rst),
      .lse_clk_pin    (pins[0]),
      .lsi_clk_pin    (pins[1]),
      .hse_clk_pin    (pins[2]),
      .bus            (bus),
      .rdata          (rdata),
      .alarm_irq      (alarm_irq),
      .periodic_irq   (periodic_irq),
      .irq            (irq),
      .cal_out        (cal_out)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Access tasks
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 got = rdata;
   endtask

   task automatic chk(input string name, input logic [31:0] exp,
                      input logic [31:0] val);
      checks_done++;
      if (val !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, val);
      end
   endtask

   task automatic rchk(input string name, input logic [7:0] a,
                       input logic [31:0] exp);
      rd(a);
      chk(name, exp, got);
   endtask

   // Source pin edges: 3 cycles high, 3 low, then let the sync settle
   task automatic pulse(input int idx, input int n);
      repeat (n) begin
         @(posedge clk);
         pins[idx] <= 1'b1;
         repeat (3) @(posedge clk);
         pins[idx] <= 1'b0;
         repeat (2) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   task automatic bkp_all(input logic zero);
      for (int i = 0; i < `RTC_BKP_NUM; i++) begin
         rchk("backup", `RTC_OFF_BKP_BASE + 8'(4 * i),
              zero ? 32'h0 : 32'h0000_A500 + 32'(i));
      end
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Ceiling well above the expected run of about 1800 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("Error timeout expected %h seen %h", 0, cycles);
         tally_and_finish();
      end
   end

   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      bkp_domain_rst = 1'b1;
      pins = 3'b000;
      bus = '0;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      bkp_domain_rst <= 1'b0;

      rchk("ctrl", `RTC_OFF_CTRL, 32'h0);
      rchk("status", `RTC_OFF_STATUS, 32'h0);
      rchk("mask", `RTC_OFF_MASK, 32'h0);
      rchk("reload", `RTC_OFF_RELOAD, 32'(`RTC_RELOAD_RST));
      rchk("presc", `RTC_OFF_PRESC, 32'(`RTC_RELOAD_RST));
      rchk("count", `RTC_OFF_COUNT, `RTC_COUNT_RST);
      rchk("alarm", `RTC_OFF_ALARM, `RTC_ALARM_RST);
      rchk("unmapped", 8'h1C, 32'h0);
      rchk("misaligned", 8'h21, 32'h0);
      $display("test reset values done");

      for (int i = 0; i < `RTC_BKP_NUM; i++) begin
         wr(`RTC_OFF_BKP_BASE + 8'(4 * i), 32'hFFFF_A500 + 32'(i));
      end
      bkp_all(1'b0);
      @(posedge clk);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      bkp_all(1'b0);
      @(posedge clk);
      bkp_domain_rst <= 1'b1;
      @(posedge clk);
      bkp_domain_rst <= 1'b0;
      bkp_all(1'b1);
      $display("test backup done");

      wr(`RTC_OFF_MASK, 32'h3);
      for (int s = 1; s <= 3; s++) begin
         wr(`RTC_OFF_RELOAD, 32'h0);
         wr(`RTC_OFF_CTRL, 32'(s * 2 + 1));
         wr(`RTC_OFF_COUNT, 32'h0);
         pulse(s - 1, (s == 3) ? 128 : 1);
         rchk("count per source", `RTC_OFF_COUNT, 32'h1);
         pulse(s % 3, 1);
         rchk("other source", `RTC_OFF_COUNT, 32'h1);
      end
      wr(`RTC_OFF_CTRL, 32'h2);
      pulse(0, 2);
      rchk("stopped", `RTC_OFF_COUNT, 32'h1);
      wr(`RTC_OFF_CTRL, 32'h1);
      pulse(0, 2);
      rchk("source off", `RTC_OFF_COUNT, 32'h1);
      $display("test sources done");

      wr(`RTC_OFF_STATUS, 32'h3);
      wr(`RTC_OFF_RELOAD, 32'h1);
      wr(`RTC_OFF_CTRL, 32'h3);
      wr(`RTC_OFF_COUNT, 32'h0);
      chk("periodic_irq idle", 32'h0, 32'(periodic_irq));
      pulse(0, 1);
      rchk("half period", `RTC_OFF_COUNT, 32'h0);
      pulse(0, 1);
      rchk("full period", `RTC_OFF_COUNT, 32'h1);
      chk("periodic_irq", 32'h1, 32'(periodic_irq));
      rchk("status periodic", `RTC_OFF_STATUS, 32'h2);
      wr(`RTC_OFF_STATUS, 32'h2);
      rchk("status cleared", `RTC_OFF_STATUS, 32'h0);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test prescaler done");

      wr(`RTC_OFF_ALARM, 32'h4);
      pulse(0, 4);
      chk("alarm_irq early", 32'h0, 32'(alarm_irq));
      pulse(0, 2);
      chk("alarm_irq", 32'h1, 32'(alarm_irq));
      chk("irq", 32'h1, 32'(irq));
      rchk("status both", `RTC_OFF_STATUS, 32'h3);
      wr(`RTC_OFF_STATUS, 32'h1);
      rchk("alarm no reset", `RTC_OFF_STATUS, 32'h2);
      wr(`RTC_OFF_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk("irq masked", 32'h0, 32'(irq));
      // Move the compare away, then back onto the count
      wr(`RTC_OFF_ALARM, 32'h5);
      wr(`RTC_OFF_ALARM, 32'h4);
      rchk("alarm by write", `RTC_OFF_STATUS, 32'h3);
      $display("test alarm done");

      wr(`RTC_OFF_CTRL, 32'hB);
      pulse(0, 16);
      chk("cal half", 32'h0, 32'(cal_out));
      pulse(0, 16);
      chk("cal high", 32'h1, 32'(cal_out));
      pulse(0, 32);
      chk("cal low", 32'h0, 32'(cal_out));
      pulse(0, 32);
      chk("cal high again", 32'h1, 32'(cal_out));
      wr(`RTC_OFF_CTRL, 32'h3);
      repeat (2) @(posedge clk);
      chk("cal off", 32'h0, 32'(cal_out));
      $display("test calibration done");

      tally_and_finish();
   end
endmodule
